// ---- hdl/dma_status_map.svh ----
// Register map and timing constants of the DMA status and time-out block.
// Assumes a 32-bit Avalon-MM slave with 12-bit byte addresses.
`ifndef DMA_STATUS_MAP_SVH
`define DMA_STATUS_MAP_SVH
// ----------------------------------------
// Sizes
// ----------------------------------------
`define CH_COUNT     10
`define ADDR_W       12
`define DATA_W       32
`define PSC_W        3
`define PSC_STRIDE   4
`define PSC_LOW_CH   8
`define PSC_BASE     4'h8
`define PSC_CNT_W    15
`define TOC_W        16
`define IRQ_W        20
`define RESET_WORD   32'h0000_0000
// ----------------------------------------
// Byte offsets
// ----------------------------------------
`define OFS_DONE     12'h424
`define OFS_ALIGN    12'h428
`define OFS_ACTIVE   12'h42C
`define OFS_PSC0     12'h430
`define OFS_TOEN     12'h434
`define OFS_TOIEN    12'h438
`define OFS_TOC01    12'h440
`define OFS_TOC23    12'h444
`define OFS_TOC45    12'h448
`define OFS_TOC67    12'h44C
`define OFS_TOC89    12'h450
`define OFS_TOFLAG   12'h454
`define OFS_SUMMARY  12'h458
`define OFS_IRQSTS   12'h45C
`define OFS_IRQMSK   12'h464
`define OFS_PSC1     12'h470
// ----------------------------------------
// Summary register bits
// ----------------------------------------
`define SUM_DONE_BIT  1
`define SUM_ALIGN_BIT 2
`endif

// ---- hdl/dma_status_pkg.sv ----
// Types shared by the DMA status and time-out block.
// Assumes the map header supplies all numeric constants.
package dma_status_pkg;
  // Per-channel events from the transfer engine, same clock
  typedef struct packed {
    logic accept;   // New request accepted
    logic done;     // Transfer completed
    logic halt;     // Channel paused or reset
    logic waiting;  // Enabled and waiting for a request
  } chan_evt_t;
  // Per-channel address low bits and width code
  typedef struct packed {
    logic [1:0] width;    // 0 byte, 1 half, 2 word
    logic [1:0] src_lsb;  // Source address bits 1:0
    logic [1:0] dst_lsb;  // Destination address bits 1:0
  } chan_addr_t;
  // Bus answer sequencer
  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;
endpackage : dma_status_pkg

// ---- hdl/dma_status_timeout.sv ----
// Status flags and peripheral request time-out of a ten-channel DMA.
// Assumes engine events on mclk; peripheral request lines are asynchronous.
`timescale 1ns/1ps
`include "dma_status_map.svh"

// Behaviour
// - Done flag sets on completion, write-one clears
// - Misalign flag follows address versus width check
// - Active flags read-only, writes ignored
// - Prescale code selects clock over 2^(8+code)
// - Prescale fields per nibble, channel seven top
// - Time-out runs only while enable bit set
// - Time-out interrupt only when irq enable set
// - Time-out after period count of ticks
// - Period counts paired, even low, odd high
// - Time-out flag sets, write-one clears
// - Read-only summary done flag from any channel
module dma_status_timeout
  import dma_status_pkg::*;
(
  input  wire logic                           mclk,
  input  wire logic                           resetn,
  input  wire logic                           ce,
  input  wire logic [`ADDR_W-1:0]             avs_address,
  input  wire logic                           avs_read,
  input  wire logic                           avs_write,
  input  wire logic [`DATA_W-1:0]             avs_writedata,
  input  wire logic [3:0]                     avs_byteenable,
  output logic      [`DATA_W-1:0]             avs_readdata,
  output logic                                avs_waitrequest,
  input  wire dma_status_pkg::chan_evt_t  [`CH_COUNT-1:0] chan_evt,
  input  wire dma_status_pkg::chan_addr_t [`CH_COUNT-1:0] chan_addr,
  input  wire logic [`CH_COUNT-1:0]           periph_req,
  output logic                                irq
);
  import dma_status_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Byte enables widened to a bit mask
  function automatic logic [`DATA_W-1:0] be_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  // Keep unselected bytes of a register word
  function automatic logic [`DATA_W-1:0] merge(input logic [`DATA_W-1:0] old_w,
                                                input logic [`DATA_W-1:0] new_w,
                                                input logic [`DATA_W-1:0] m);
    return (old_w & ~m) | (new_w & m);
  endfunction : merge

  // Address not a multiple of the transfer width
  function automatic logic misaligned(input chan_addr_t a);
    case (a.width)
      2'h0:    return 1'b0;
      2'h1:    return a.src_lsb[0] | a.dst_lsb[0];
      default: return (|a.src_lsb) | (|a.dst_lsb);
    endcase
  endfunction : misaligned

  // Tick once every 2^(8+code) clocks: all bits below the span are ones
  function automatic logic psc_tick(input logic [`PSC_W-1:0] code,
                                    input logic [`PSC_CNT_W-1:0] cnt);
    logic [`PSC_CNT_W:0] span;
    span = (`PSC_CNT_W+1)'(1) << (`PSC_BASE + {1'b0, code});
    return &(cnt | ~(span[`PSC_CNT_W-1:0] - 1'b1));
  endfunction : psc_tick

  // ----------------------------------------
  // State
  // ----------------------------------------
  bus_state_t                  bus_state_reg;      // Answer sequencer
  logic [`DATA_W-1:0]          readdata_reg;       // Registered read data
  logic [`CH_COUNT-1:0]        done_flag_reg;      // Transfer-done flags
  logic [`CH_COUNT-1:0]        misalign_reg;       // Misalignment flags
  logic [`CH_COUNT-1:0]        active_reg;         // Channel-active flags
  logic [`CH_COUNT-1:0]        toen_reg;           // Time-out enables
  logic [`CH_COUNT-1:0]        toien_reg;          // Time-out irq enables
  logic [`CH_COUNT-1:0]        toflag_reg;         // Request time-out flags
  logic [`PSC_W-1:0]           prescale_reg [`CH_COUNT];
  logic [`TOC_W-1:0]           toc_reg      [`CH_COUNT];
  logic [`TOC_W-1:0]           to_cnt_reg   [`CH_COUNT];
  logic [`PSC_CNT_W-1:0]       psc_cnt_reg;        // Shared prescaler
  logic [`CH_COUNT-1:0]        req_meta_reg;       // Sync stage one
  logic [`CH_COUNT-1:0]        req_sync_reg;       // Sync stage two
  logic [`IRQ_W-1:0]           irq_status_reg;     // Sticky events
  logic [`IRQ_W-1:0]           irq_mask_reg;       // Event mask

  logic                        wr_fire;            // Write takes effect
  logic                        rd_fire;            // Read completes
  logic [`DATA_W-1:0]          wmask;              // Byte lane mask
  logic [`DATA_W-1:0]          w1c;                // Write-one bits
  logic [`DATA_W-1:0]          psc0_img;           // Prescale word 0
  logic [`DATA_W-1:0]          psc1_img;           // Prescale word 1
  logic [`DATA_W-1:0]          rd_word;            // Decoded read value
  logic [`CH_COUNT-1:0]        done_evt;           // Done pulses
  logic [`CH_COUNT-1:0]        tick;               // Per-channel ticks
  logic [`CH_COUNT-1:0]        to_run;             // Counter may run
  logic [`CH_COUNT-1:0]        to_hit;             // Time-out this cycle
  logic [`CH_COUNT-1:0]        done_clr;           // Software clears
  logic [`CH_COUNT-1:0]        toflag_clr;         // Software clears

  // ----------------------------------------
  // Avalon-MM slave, one wait state
  // ----------------------------------------
  // First request cycle stalls while read data is captured
  // A frozen block keeps stalling, so no answer is lost while ce is low
  assign avs_waitrequest = (avs_read | avs_write) & ~(ce & (bus_state_reg == BUS_ANSWER));
  assign wr_fire = ce & avs_write & (bus_state_reg == BUS_ANSWER);
  assign rd_fire = ce & avs_read & (bus_state_reg == BUS_ANSWER);
  assign wmask   = be_mask(avs_byteenable);
  assign w1c     = avs_writedata & wmask;
  assign avs_readdata = readdata_reg;

  // Sequencer: one answer per request
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      bus_state_reg <= BUS_IDLE;
    end else if (ce) begin
      case (bus_state_reg)
        BUS_IDLE:   if (avs_read | avs_write) bus_state_reg <= BUS_ANSWER;
        BUS_ANSWER: bus_state_reg <= BUS_IDLE;
        default:    bus_state_reg <= BUS_IDLE;
      endcase
    end
  end

  // Register images of packed fields
  always_comb begin
    psc0_img = `RESET_WORD;
    psc1_img = `RESET_WORD;
    for (int i = 0; i < `CH_COUNT; i++) begin
      if (i < `PSC_LOW_CH) begin
        psc0_img[i*`PSC_STRIDE +: `PSC_W] = prescale_reg[i];
      end else begin
        psc1_img[(i-`PSC_LOW_CH)*`PSC_STRIDE +: `PSC_W] = prescale_reg[i];
      end
    end
  end

  // Read decode; unmapped offsets read zero
  always_comb begin
    rd_word = `RESET_WORD;
    case (avs_address)
      `OFS_DONE:    rd_word[`CH_COUNT-1:0] = done_flag_reg;
      `OFS_ALIGN:   rd_word[`CH_COUNT-1:0] = misalign_reg;
      `OFS_ACTIVE:  rd_word[`CH_COUNT-1:0] = active_reg;
      `OFS_PSC0:    rd_word = psc0_img;
      `OFS_PSC1:    rd_word = psc1_img;
      `OFS_TOEN:    rd_word[`CH_COUNT-1:0] = toen_reg;
      `OFS_TOIEN:   rd_word[`CH_COUNT-1:0] = toien_reg;
      `OFS_TOC01:   rd_word = {toc_reg[1], toc_reg[0]};
      `OFS_TOC23:   rd_word = {toc_reg[3], toc_reg[2]};
      `OFS_TOC45:   rd_word = {toc_reg[5], toc_reg[4]};
      `OFS_TOC67:   rd_word = {toc_reg[7], toc_reg[6]};
      `OFS_TOC89:   rd_word = {toc_reg[9], toc_reg[8]};
      `OFS_TOFLAG:  rd_word[`CH_COUNT-1:0] = toflag_reg;
      `OFS_SUMMARY: begin
        rd_word[`SUM_DONE_BIT]  = |done_flag_reg;
        rd_word[`SUM_ALIGN_BIT] = |misalign_reg;
      end
      `OFS_IRQSTS:  rd_word[`IRQ_W-1:0] = irq_status_reg;
      `OFS_IRQMSK:  rd_word[`IRQ_W-1:0] = irq_mask_reg;
      default:      rd_word = `RESET_WORD;
    endcase
  end

  // Capture read data one cycle ahead of the answer
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      readdata_reg <= `RESET_WORD;
    end else if (ce && avs_read && bus_state_reg == BUS_IDLE) begin
      readdata_reg <= rd_word;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Enables and irq mask
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      toen_reg     <= '0;
      toien_reg    <= '0;
      irq_mask_reg <= '0;
    end else if (wr_fire) begin
      if (avs_address == `OFS_TOEN)
        toen_reg <= merge({22'h0, toen_reg}, avs_writedata, wmask)
                    [`CH_COUNT-1:0];
      if (avs_address == `OFS_TOIEN)
        toien_reg <= merge({22'h0, toien_reg}, avs_writedata, wmask)
                     [`CH_COUNT-1:0];
      if (avs_address == `OFS_IRQMSK)
        irq_mask_reg <= merge({12'h0, irq_mask_reg}, avs_writedata, wmask)
                        [`IRQ_W-1:0];
    end
  end

  // Prescale codes, one nibble per channel
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < `CH_COUNT; i++) prescale_reg[i] <= '0;
    end else if (wr_fire) begin
      for (int i = 0; i < `CH_COUNT; i++) begin
        if (i < `PSC_LOW_CH && avs_address == `OFS_PSC0)
          prescale_reg[i] <= merge(psc0_img, avs_writedata, wmask)
                             [i*`PSC_STRIDE +: `PSC_W];
        if (i >= `PSC_LOW_CH && avs_address == `OFS_PSC1)
          prescale_reg[i] <= merge(psc1_img, avs_writedata, wmask)
                             [(i-`PSC_LOW_CH)*`PSC_STRIDE +: `PSC_W];
      end
    end
  end

  // Period counts, two channels per word
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < `CH_COUNT; i++) toc_reg[i] <= '0;
    end else if (wr_fire) begin
      for (int k = 0; k < `CH_COUNT/2; k++) begin
        if (avs_address == `ADDR_W'(`OFS_TOC01 + 4*k)) begin
          // Even channel low half, odd channel high half
          {toc_reg[2*k+1], toc_reg[2*k]} <=
            merge({toc_reg[2*k+1], toc_reg[2*k]}, avs_writedata, wmask);
        end
      end
    end
  end

  // ----------------------------------------
  // Channel status flags
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < `CH_COUNT; i++) done_evt[i] = chan_evt[i].done;
  end
  assign done_clr   = (wr_fire && avs_address == `OFS_DONE) ?
                      w1c[`CH_COUNT-1:0] : '0;
  assign toflag_clr = (wr_fire && avs_address == `OFS_TOFLAG) ?
                      w1c[`CH_COUNT-1:0] : '0;

  // Done flags: a completion in the clear cycle wins
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      done_flag_reg <= '0;
    end else if (ce) begin
      done_flag_reg <= (done_flag_reg & ~done_clr) | done_evt;
    end
  end

  // Misalignment follows the live addresses; writes do not alter it
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      misalign_reg <= '0;
    end else if (ce) begin
      for (int i = 0; i < `CH_COUNT; i++)
        misalign_reg[i] <= misaligned(chan_addr[i]);
    end
  end

  // Active flags, hardware only; a new accept beats a clear
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      active_reg <= '0;
    end else if (ce) begin
      for (int i = 0; i < `CH_COUNT; i++) begin
        if (chan_evt[i].accept)
          active_reg[i] <= 1'b1;
        else if (chan_evt[i].done || chan_evt[i].halt)
          active_reg[i] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Request time-out
  // ----------------------------------------
  // Peripheral request lines are asynchronous
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      req_meta_reg <= '0;
      req_sync_reg <= '0;
    end else if (ce) begin
      req_meta_reg <= periph_req;
      req_sync_reg <= req_meta_reg;
    end
  end

  // Shared free-running prescaler; first tick after a restart may be
  // short by up to one tick, traded for a single counter
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      psc_cnt_reg <= '0;
    end else if (ce) begin
      psc_cnt_reg <= psc_cnt_reg + 1'b1;
    end
  end

  // Per-channel tick, run and hit terms
  always_comb begin
    for (int i = 0; i < `CH_COUNT; i++) begin
      tick[i]   = psc_tick(prescale_reg[i], psc_cnt_reg);
      to_run[i] = toen_reg[i] & chan_evt[i].waiting & ~req_sync_reg[i];
      to_hit[i] = to_run[i] & tick[i] & (toc_reg[i] != '0) &
                  (to_cnt_reg[i] == toc_reg[i] - 1'b1);
    end
  end

  // Tick counters: restart on request or when idle
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < `CH_COUNT; i++) to_cnt_reg[i] <= '0;
    end else if (ce) begin
      for (int i = 0; i < `CH_COUNT; i++) begin
        if (!to_run[i] || to_hit[i])
          to_cnt_reg[i] <= '0;
        else if (tick[i])
          to_cnt_reg[i] <= to_cnt_reg[i] + 1'b1;
      end
    end
  end

  // Time-out flags: event wins over write-one clear
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      toflag_reg <= '0;
    end else if (ce) begin
      toflag_reg <= (toflag_reg & ~toflag_clr) | to_hit;
    end
  end

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  // Bits 9:0 done events, 19:10 time-outs gated by their irq enable;
  // a read clears, an event in the same cycle survives
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      irq_status_reg <= '0;
    end else if (ce) begin
      irq_status_reg <= ((rd_fire && avs_address == `OFS_IRQSTS) ?
                         '0 : irq_status_reg) |
                        {to_hit & toien_reg, done_evt};
    end
  end

  // Level output from registered status and mask
  assign irq = |(irq_status_reg & irq_mask_reg);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  for (genvar g = 0; g < `CH_COUNT; g++) begin : g_chk
    a_done_sets: assert property (@(posedge mclk) disable iff (!resetn)
      ce && chan_evt[g].done |=> done_flag_reg[g])
      else $error("done flag not set");
    a_done_holds: assert property (@(posedge mclk) disable iff (!resetn)
      done_flag_reg[g] && !(ce && done_clr[g]) |=> done_flag_reg[g])
      else $error("done flag lost");
    a_misalign_byte: assert property (@(posedge mclk) disable iff (!resetn)
      ce && chan_addr[g].width == 2'h0 |=> !misalign_reg[g])
      else $error("byte transfer flagged misaligned");
    a_active_noset: assert property (@(posedge mclk) disable iff (!resetn)
      !active_reg[g] && !(ce && chan_evt[g].accept) |=> !active_reg[g])
      else $error("active set without accept");
    a_active_clears: assert property (@(posedge mclk) disable iff (!resetn)
      ce && chan_evt[g].done && !chan_evt[g].accept |=> !active_reg[g])
      else $error("active not cleared");
    a_tout_disabled: assert property (@(posedge mclk) disable iff (!resetn)
      !toen_reg[g] |-> !to_hit[g] ##1 !$rose(toflag_reg[g]) || toen_reg[g])
      else $error("time-out while disabled");
    a_tout_flag: assert property (@(posedge mclk) disable iff (!resetn)
      ce && to_hit[g] |=> toflag_reg[g])
      else $error("time-out flag not set");
    a_tout_irq_gate: assert property (@(posedge mclk) disable iff (!resetn)
      ce && to_hit[g] && !toien_reg[g] && !irq_status_reg[`CH_COUNT+g]
      |=> !irq_status_reg[`CH_COUNT+g])
      else $error("time-out irq without enable");
    a_req_restart: assert property (@(posedge mclk) disable iff (!resetn)
      ce && req_sync_reg[g] |=> to_cnt_reg[g] == '0)
      else $error("counter not restarted");
    a_tick_span: assert property (@(posedge mclk) disable iff (!resetn)
      tick[g] && prescale_reg[g] == 3'h0 |-> &psc_cnt_reg[7:0])
      else $error("tick off period");
    a_tout_count: assert property (@(posedge mclk) disable iff (!resetn)
      to_hit[g] |-> to_cnt_reg[g] + 1'b1 == toc_reg[g])
      else $error("time-out at wrong count");
  end

  a_psc_layout: assert property (@(posedge mclk) disable iff (!resetn)
    wr_fire && avs_address == `OFS_PSC0 && avs_byteenable[3]
    |=> prescale_reg[7] == $past(avs_writedata[30:28]))
    else $error("prescale field misplaced");
  a_toc_layout: assert property (@(posedge mclk) disable iff (!resetn)
    wr_fire && avs_address == `OFS_TOC01 && (&avs_byteenable)
    |=> toc_reg[1] == $past(avs_writedata[31:16]))
    else $error("period count misplaced");

endmodule : dma_status_timeout

// ---- verification/far_end_model.sv ----
// Far side of the block: engine events, address bits, peripheral requests.
// Assumes one clock; every change lands by non-blocking assignment after a rising edge.
`timescale 1ns/1ps
`include "dma_status_map.svh"
module far_end_model
  import dma_status_pkg::*;
(
  input  wire logic                                   mclk,
  output dma_status_pkg::chan_evt_t  [`CH_COUNT-1:0] chan_evt,
  output dma_status_pkg::chan_addr_t [`CH_COUNT-1:0] chan_addr,
  output logic [`CH_COUNT-1:0]                        periph_req
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  initial begin
    chan_evt = '0;
    chan_addr = '0;
    periph_req = '0;
  end
  // One-cycle engine pulse: 0 accept, 1 done, 2 halt
  task automatic pulse(input int ch, input int kind);
    @(posedge mclk);
    chan_evt[ch].accept <= (kind == 0);
    chan_evt[ch].done   <= (kind == 1);
    chan_evt[ch].halt   <= (kind == 2);
    @(posedge mclk);
    chan_evt[ch].accept <= 1'b0;
    chan_evt[ch].done   <= 1'b0;
    chan_evt[ch].halt   <= 1'b0;
  endtask : pulse
  // Waiting levels and request lines; a held request keeps the count at zero
  task automatic set_wait(input logic [`CH_COUNT-1:0] w, input logic [`CH_COUNT-1:0] r);
    @(posedge mclk);
    for (int i = 0; i < `CH_COUNT; i++) begin
      chan_evt[i].waiting <= w[i];
    end
    periph_req <= r;
  endtask : set_wait
  // Address low bits against transfer width
  task automatic set_addr(input int ch, input logic [5:0] a);
    @(posedge mclk);
    chan_addr[ch] <= a;
  endtask : set_addr
endmodule : far_end_model

// ---- verification/test_dma_status_timeout.sv ----
// Self-checking bench of the status and time-out block over Avalon-MM.
// Assumes the far-side model drives all engine and request inputs.
`timescale 1ns/1ps
`include "dma_status_map.svh"
module test_dma_status_timeout;
  import dma_status_pkg::*;
  logic                       mclk = 1'b0;    // 40 MHz
  logic                       resetn = 1'b0;  // Active low
  logic [`ADDR_W-1:0]         avs_address = '0;
  logic                       avs_read = 1'b0;
  logic                       avs_write = 1'b0;
  logic [`DATA_W-1:0]         avs_writedata = '0;
  logic [`DATA_W-1:0]         avs_readdata;
  logic                       avs_waitrequest;
  chan_evt_t  [`CH_COUNT-1:0] chan_evt;
  chan_addr_t [`CH_COUNT-1:0] chan_addr;
  logic [`CH_COUNT-1:0]       periph_req;
  logic                       irq;
  int                         failures = 0;
  int                         compares = 0;
  logic [31:0]                d;
  always #12.5 mclk = ~mclk;
  dma_status_timeout u_dut (.mclk(mclk), .resetn(resetn), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .chan_evt(chan_evt),
    .chan_addr(chan_addr), .periph_req(periph_req), .irq(irq));
  far_end_model u_far (.mclk(mclk), .chan_evt(chan_evt), .chan_addr(chan_addr), .periph_req(periph_req));
  // ----------------------------------------
  // Bus tasks: hold the request until waitrequest is seen low
  // ----------------------------------------
  task automatic bus(input logic [11:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  // Read one register and compare it
  task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(a, 1'b0, '0, v);
    check(n, v, exp);
  endtask : rchk
  task automatic print_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  logic [11:0] ofs [12] = '{12'h424, 12'h428, 12'h42C, 12'h430, 12'h434, 12'h438, 12'h440, 12'h444,
                            12'h448, 12'h44C, 12'h450, 12'h470};
  logic [31:0] ones [12] = '{32'h0, 32'h0, 32'h0, 32'h7777_7777, 32'h3FF, 32'h3FF, 32'hFFFF_FFFF,
                             32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h77};
  initial begin
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    foreach (ofs[i]) rchk("reset", ofs[i], 32'h0);
    // All-ones write: reserved bits drop, status places ignore it
    foreach (ofs[i]) begin
      bus(ofs[i], 1'b1, 32'hFFFF_FFFF, d);
      rchk("ones", ofs[i], ones[i]);
      bus(ofs[i], 1'b1, 32'h0, d);
    end
    bus(12'h47C, 1'b1, 32'hFFFF_FFFF, d);
    rchk("unmapped", 12'h47C, 32'h0);
    // Active flag follows accept, done and halt
    u_far.pulse(3, 0);
    u_far.pulse(5, 0);
    rchk("active", `OFS_ACTIVE, 32'h28);
    u_far.pulse(3, 1);
    u_far.pulse(5, 2);
    rchk("active", `OFS_ACTIVE, 32'h0);
    rchk("done", `OFS_DONE, 32'h8);
    rchk("summary", `OFS_SUMMARY, 32'h2);
    check("irq masked", {31'h0, irq}, 32'h0);
    bus(`OFS_IRQMSK, 1'b1, 32'h3FF, d);
    @(posedge mclk);
    check("irq", {31'h0, irq}, 32'h1);
    rchk("irqsts", `OFS_IRQSTS, 32'h8);
    @(posedge mclk);
    check("irq clr", {31'h0, irq}, 32'h0);
    bus(`OFS_DONE, 1'b1, 32'h4, d);
    rchk("done", `OFS_DONE, 32'h8);
    bus(`OFS_DONE, 1'b1, 32'h8, d);
    rchk("done", `OFS_DONE, 32'h0);
    rchk("summary", `OFS_SUMMARY, 32'h0);
    // Misalignment: word width with odd source address
    u_far.set_addr(2, 6'b10_01_00);
    rchk("align", `OFS_ALIGN, 32'h4);
    bus(`OFS_ALIGN, 1'b1, 32'h0, d);
    rchk("align", `OFS_ALIGN, 32'h4);
    u_far.set_addr(2, 6'b01_10_00);
    rchk("align", `OFS_ALIGN, 32'h0);
    // Time-out: ch0/1 code 0 period 2, ch4 code 1 period 3, ch2 off, ch3 requested
    u_far.set_wait(10'h01F, 10'h008);
    bus(`OFS_IRQMSK, 1'b1, 32'hFFC00, d);
    bus(`OFS_PSC0, 1'b1, 32'h0001_0000, d);
    bus(`OFS_TOC01, 1'b1, 32'h0002_0002, d);
    bus(`OFS_TOC23, 1'b1, 32'h0001_0001, d);
    bus(`OFS_TOC45, 1'b1, 32'h0000_0003, d);
    bus(`OFS_TOIEN, 1'b1, 32'h1, d);
    bus(`OFS_TOEN, 1'b1, 32'h1B, d);
    repeat (240) @(posedge mclk);
    rchk("tflag early", `OFS_TOFLAG, 32'h0);
    repeat (360) @(posedge mclk);
    rchk("tflag", `OFS_TOFLAG, 32'h3);
    check("irq tout", {31'h0, irq}, 32'h1);
    rchk("irqsts", `OFS_IRQSTS, 32'h400);
    repeat (1000) @(posedge mclk);
    rchk("tflag slow", `OFS_TOFLAG, 32'h13);
    u_far.set_wait(10'h0, 10'h0);
    bus(`OFS_TOEN, 1'b1, 32'h0, d);
    bus(`OFS_TOFLAG, 1'b1, 32'h13, d);
    rchk("tflag clr", `OFS_TOFLAG, 32'h0);
    print_verdict();
  end
  // Watchdog: the sequence needs about 1900 cycles
  initial begin
    repeat (10000) @(posedge mclk);
    failures++;
    print_verdict();
  end
endmodule : test_dma_status_timeout
